// ### design/nac_pkg.sv
// package: register map, field layout and timing for the nvm access block
`default_nettype none

package nac_pkg;

    localparam int           IO_AW        = 6;
    localparam logic [5:0]   OFF_CTRL     = 6'h1c;
    localparam logic [5:0]   OFF_DATA     = 6'h1d;
    localparam logic [5:0]   OFF_ADDR     = 6'h1e;

    localparam int           NVM_AW       = 7;
    localparam int           NVM_DEPTH    = 128;

    localparam int           BIT_ARM      = 2;
    localparam int           BIT_WSTB     = 1;
    localparam int           BIT_RSTB     = 0;

    localparam logic [7:0]   RST_BYTE     = 8'h00;
    localparam logic [7:0]   ZERO_BYTE    = 8'h00;

    localparam int           STALL_CYC    = 2;
    localparam int           ARM_CYC      = 4;

    localparam int           CLK_MHZ      = 100;
    localparam int           WRITE_TIME_US = 4000;
    localparam int           WRITE_CYC    = WRITE_TIME_US * CLK_MHZ;

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [IO_AW-1:0]    addr;
        logic [7:0]          wdata;
    } nac_io_req_type;

    typedef struct packed {
        logic                ack;
        logic [7:0]          rdata;
    } nac_io_rsp_type;

endpackage : nac_pkg

`default_nettype wire

// ### design/nac_array.sv
// module: 128-byte nonvolatile storage model with byte read and write
`default_nettype none

module nac_array #(
    parameter int AW = 7
) (
    input  wire logic          clk,    // system clock
    input  wire logic          we,     // commit byte
    input  wire logic [AW-1:0] addr,   // byte index
    input  wire logic [7:0]    wdata,  // byte to store
    output var  logic [7:0]    rdata   // registered read byte
);
    import nac_pkg::*;

    logic [7:0] mem [0:(1<<AW)-1];

    // no reset: contents model retained storage
    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        rdata <= mem[addr];
    end

endmodule : nac_array

`default_nettype wire

// ### design/nac_timer.sv
// module: programming interval counter, busy from start until terminal count or abort
`default_nettype none

module nac_timer #(
    parameter int CYCLES = 400000
) (
    input  wire logic clk,    // system clock
    input  wire logic nrst,   // sync reset, active low
    input  wire logic start,  // begin interval
    input  wire logic abort,  // cut interval short
    output var  logic busy,   // interval running
    output var  logic done    // pulse at end
);
    import nac_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_ff;

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            count_ff <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
        end
        else if (start)
        begin
            count_ff <= '0;
            busy     <= 1'b1;
            done     <= 1'b0;
        end
        // abort stops the count without a done pulse, so nothing commits
        else if (busy && abort)
        begin
            busy     <= 1'b0;
            done     <= 1'b0;
        end
        else if (busy && count_ff == LAST)
        begin
            busy     <= 1'b0;
            done     <= 1'b1;
        end
        else
        begin
            count_ff <= busy ? count_ff + 1'b1 : count_ff;
            done     <= 1'b0;
        end
    end

endmodule : nac_timer

`default_nettype wire

// ### design/nac_ctrl.sv
// module: nvm access controller with io registers, arm window and stall
`default_nettype none

module nac_ctrl #(
    parameter int WRITE_CYCLES = nac_pkg::WRITE_CYC
) (
    input  wire logic                    clk,      // system clock
    input  wire logic                    nrst,     // sync reset, active low
    input  wire nac_pkg::nac_io_req_type ioReq,    // io register access
    output var  nac_pkg::nac_io_rsp_type ioRsp,    // io read data and hit
    output var  logic                    cpuStall  // halt processor
);
    import nac_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } nac_state_type;

    nac_state_type state_ff;
    nac_state_type nxt_state;

    logic [NVM_AW-1:0] addr_ff;
    logic [7:0]        data_ff;
    logic              arm_ff;
    logic              wstb_ff;
    logic              rstb_ff;
    logic [2:0]        armCnt_ff;
    logic [1:0]        stall_ff;

    logic [7:0] arrRd;
    logic       tBusy;
    logic       tDone;
    logic       arrWe;

    function automatic logic hit(input logic [IO_AW-1:0] a,
                                 input logic [IO_AW-1:0] off);
        hit = (a == off);
    endfunction : hit

    logic wrCtrl;
    logic wrData;
    logic wrAddr;
    logic wStart;
    logic rStart;
    logic regChange;

    assign wrCtrl = ioReq.wr && hit(ioReq.addr, OFF_CTRL);
    assign wrData = ioReq.wr && hit(ioReq.addr, OFF_DATA);
    assign wrAddr = ioReq.wr && hit(ioReq.addr, OFF_ADDR);

    // strobe only counts while armed and no write already running
    assign wStart = wrCtrl && ioReq.wdata[BIT_WSTB] && arm_ff
                    && !wstb_ff;
    assign rStart = wrCtrl && ioReq.wdata[BIT_RSTB] && !wStart
                    && state_ff == ST_IDLE;
    // address or data change during a write cuts it short
    assign regChange = (wrData || wrAddr) && state_ff == ST_WRITE;

    ////////////////////////////////////////////////////////////////////
    // state machine

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (wStart)
                    nxt_state = ST_WRITE;
                else if (rStart)
                    nxt_state = ST_READ;
            end
            ST_READ:  nxt_state = ST_IDLE;
            ST_WRITE:
            begin
                if (tDone || regChange)
                    nxt_state = ST_IDLE;
            end
            default:  nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    ////////////////////////////////////////////////////////////////////
    // address and data registers

    always_ff @(posedge clk)
    begin
        if (!nrst)
            addr_ff <= RST_BYTE[NVM_AW-1:0];
        else if (wrAddr)
            addr_ff <= ioReq.wdata[NVM_AW-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            data_ff <= RST_BYTE;
        else if (state_ff == ST_READ)
            data_ff <= arrRd;
        else if (wrData)
            data_ff <= ioReq.wdata;
    end

    ////////////////////////////////////////////////////////////////////
    // arm bit with four-cycle lifetime

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            arm_ff    <= 1'b0;
            armCnt_ff <= '0;
        end
        else if (wrCtrl && ioReq.wdata[BIT_ARM])
        begin
            arm_ff    <= 1'b1;
            armCnt_ff <= 3'(ARM_CYC - 1);
        end
        else if (arm_ff && armCnt_ff == '0)
            arm_ff    <= 1'b0;
        else if (arm_ff)
            armCnt_ff <= armCnt_ff - 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // strobes

    // done set in the same cycle as a new start cannot occur: start needs
    // the strobe low, done only fires while it is high
    always_ff @(posedge clk)
    begin
        if (!nrst)
            wstb_ff <= 1'b0;
        else if (wStart)
            wstb_ff <= 1'b1;
        else if (tDone || regChange)
            wstb_ff <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            rstb_ff <= 1'b0;
        else if (rStart)
            rstb_ff <= 1'b1;
        else if (state_ff == ST_READ)
            rstb_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // processor stall

    always_ff @(posedge clk)
    begin
        if (!nrst)
            stall_ff <= '0;
        else if (wStart || rStart)
            stall_ff <= 2'(STALL_CYC);
        else if (stall_ff != '0)
            stall_ff <= stall_ff - 1'b1;
    end

    assign cpuStall = (stall_ff != '0);

    ////////////////////////////////////////////////////////////////////
    // storage and timing

    // abort never pulses done, so only a full interval commits
    assign arrWe = tDone && state_ff == ST_WRITE;

    nac_array #(
        .AW    (NVM_AW)
    ) u_array (
        .clk   (clk),
        .we    (arrWe),
        .addr  (addr_ff),
        .wdata (data_ff),
        .rdata (arrRd)
    );

    nac_timer #(
        .CYCLES (WRITE_CYCLES)
    ) u_timer (
        .clk   (clk),
        .nrst  (nrst),
        .start (wStart),
        .abort (regChange),
        .busy  (tBusy),
        .done  (tDone)
    );

    ////////////////////////////////////////////////////////////////////
    // read-back

    always_ff @(posedge clk)
    begin
        if (!nrst)
            ioRsp <= '0;
        else if (!ioReq.rd)
            ioRsp <= '0;
        else if (hit(ioReq.addr, OFF_CTRL))
            ioRsp <= {1'b1, 5'b0_0000, arm_ff, wstb_ff, rstb_ff};
        else if (hit(ioReq.addr, OFF_DATA))
            ioRsp <= {1'b1, data_ff};
        else if (hit(ioReq.addr, OFF_ADDR))
            ioRsp <= {1'b1, 1'b0, addr_ff};
        else
            ioRsp <= {1'b0, ZERO_BYTE};
    end

    ////////////////////////////////////////////////////////////////////
    // checks

    a_stall_two: assert property (@(posedge clk) disable iff (!nrst)
        (wStart || rStart) |=> cpuStall [*2] ##1 !cpuStall)
        else $error("stall not two cycles");

    a_arm_expire: assert property (@(posedge clk) disable iff (!nrst)
        (wrCtrl && ioReq.wdata[BIT_ARM]) ##1
        !(wrCtrl && ioReq.wdata[BIT_ARM]) [*4] |=> !arm_ff)
        else $error("arm bit outlived window");

    a_arm_needed: assert property (@(posedge clk) disable iff (!nrst)
        (wrCtrl && ioReq.wdata[BIT_WSTB] && !arm_ff && !wstb_ff)
        |=> !wstb_ff)
        else $error("write started unarmed");

    a_wstb_hold: assert property (@(posedge clk) disable iff (!nrst)
        tBusy |-> wstb_ff)
        else $error("write strobe dropped early");

    a_wstb_clear: assert property (@(posedge clk) disable iff (!nrst)
        tDone |=> !wstb_ff)
        else $error("write strobe not cleared");

    a_abort_drop: assert property (@(posedge clk) disable iff (!nrst)
        regChange |=> !wstb_ff && !tBusy && !tDone)
        else $error("aborted write not dropped");

    a_read_done: assert property (@(posedge clk) disable iff (!nrst)
        rStart |=> rstb_ff ##1 !rstb_ff && data_ff == $past(arrRd))
        else $error("read not completed");

    a_rsv_zero: assert property (@(posedge clk) disable iff (!nrst)
        $past(ioReq.rd && hit(ioReq.addr, OFF_ADDR)) |-> !ioRsp.rdata[7])
        else $error("reserved address bit set");

    a_ctrl_rsv: assert property (@(posedge clk) disable iff (!nrst)
        $past(ioReq.rd && hit(ioReq.addr, OFF_CTRL))
        |-> ioRsp.rdata[7:3] == 5'b0_0000)
        else $error("reserved control bits set");

endmodule : nac_ctrl

`default_nettype wire

// ### tb/nac_cpu_model.sv
// cpu-side io master model for the nvm access block
`default_nettype none

module nac_cpu_model (
    input  wire logic                    clk,      // system clock
    input  wire logic                    cpuStall, // core halt
    input  wire nac_pkg::nac_io_rsp_type ioRsp,    // io response
    output var  nac_pkg::nac_io_req_type ioReq     // io request
);
    timeunit 1ns;
    timeprecision 1ps;
    import nac_pkg::*;

    initial ioReq = '0;

    // a halted core issues nothing
    task automatic waitRun();
        for (int n = 0; n < 8 && cpuStall !== 1'b0; n++)
            @(negedge clk);
    endtask : waitRun

    // idle cycle after each access keeps one assignment per step
    task automatic ioWrite(input logic [5:0] a, input logic [7:0] d);
        waitRun();
        ioReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        ioReq = '0;
        @(negedge clk);
    endtask : ioWrite

    task automatic ioRead(input logic [5:0] a, output logic [7:0] d,
                          output logic h);
        waitRun();
        ioReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        ioReq = '0;
        h = ioRsp.ack;
        d = ioRsp.rdata;
        @(negedge clk);
        if (h !== 1'b1)
        begin
            h = ioRsp.ack;
            d = ioRsp.rdata;
        end
    endtask : ioRead

    // ok low means the poll limit ran out with the strobe still set
    task automatic waitIdle(output logic ok);
        logic [7:0] c;
        logic       h;
        c = 8'hff;
        for (int n = 0; n < 64 && c[BIT_WSTB] !== 1'b0; n++)
            ioRead(OFF_CTRL, c, h);
        ok = (c[BIT_WSTB] === 1'b0);
    endtask : waitIdle

    task automatic writeByte(input logic [6:0] loc, input logic [7:0] d,
                             output logic ok);
        waitIdle(ok);
        ioWrite(OFF_ADDR, {1'b0, loc});
        ioWrite(OFF_DATA, d);
        ioWrite(OFF_CTRL, 8'h04);
        ioWrite(OFF_CTRL, 8'h02);
    endtask : writeByte
endmodule : nac_cpu_model

`default_nettype wire

// ### tb/nac_ctrl_tb.sv
// self-checking bench for the nvm access controller
`default_nettype none

module nac_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nac_pkg::*;
    localparam int  WCYC = 20;
    logic           clk = 1'b0;
    logic           nrst = 1'b0;
    logic           cpuStall;
    nac_io_req_type ioReq;
    nac_io_rsp_type ioRsp;
    int             miscompares = 0;
    int             totalChecks = 0;
    int             stallCount = 0;
    int             cycleCount = 0;

    nac_ctrl #(.WRITE_CYCLES(WCYC)) uut (
        .clk(clk), .nrst(nrst), .ioReq(ioReq), .ioRsp(ioRsp),
        .cpuStall(cpuStall));
    nac_cpu_model cpu (
        .clk(clk), .cpuStall(cpuStall), .ioRsp(ioRsp), .ioReq(ioReq));

    always #5 clk = ~clk;
    always @(negedge clk)
    begin
        cycleCount++;
        if (cpuStall === 1'b1)
            stallCount++;
    end

////////////////////////////////////////
    task automatic check(input string w, input logic [7:0] e,
                         input logic [7:0] g);
        totalChecks++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask : check

    task automatic expectReg(input string w, input logic [5:0] a,
                             input logic [7:0] e);
        logic [7:0] d;
        logic       h;
        cpu.ioRead(a, d, h);
        check({w, " ack"}, 8'h01, {7'h00, h});
        check(w, e, d);
    endtask : expectReg

    task automatic readBack(input logic [6:0] loc, input logic [7:0] e);
        logic ok;
        cpu.waitIdle(ok);
        check("read idle", 8'h01, {7'h00, ok});
        cpu.ioWrite(OFF_ADDR, {1'b0, loc});
        stallCount = 0;
        cpu.ioWrite(OFF_CTRL, 8'h01);
        expectReg("read done", OFF_CTRL, 8'h00);
        expectReg("read data", OFF_DATA, e);
        check("read stall", 8'h02, 8'(stallCount));
    endtask : readBack

    task automatic t_reset();
        logic [7:0] d;
        logic       h;
        expectReg("ctrl rst", OFF_CTRL, 8'h00);
        expectReg("data rst", OFF_DATA, 8'h00);
        expectReg("addr rst", OFF_ADDR, 8'h00);
        cpu.ioRead(6'h1f, d, h);
        check("free ack", 8'h00, {7'h00, h});
        check("free data", 8'h00, d);
    endtask : t_reset

    task automatic t_bits();
        stallCount = 0;
        cpu.ioWrite(OFF_ADDR, 8'hff);
        expectReg("addr bits", OFF_ADDR, 8'h7f);
        cpu.ioWrite(OFF_CTRL, 8'hf8);
        expectReg("ctrl bits", OFF_CTRL, 8'h00);
        cpu.ioWrite(OFF_CTRL, 8'h02);
        expectReg("no arm", OFF_CTRL, 8'h00);
        cpu.ioWrite(OFF_CTRL, 8'h04);
        expectReg("armed", OFF_CTRL, 8'h04);
        repeat (2) @(negedge clk);
        cpu.ioWrite(OFF_CTRL, 8'h02);
        expectReg("arm gone", OFF_CTRL, 8'h00);
        check("no stall", 8'h00, 8'(stallCount));
    endtask : t_bits

    task automatic t_write();
        int   t0;
        logic ok;
        stallCount = 0;
        cpu.ioWrite(OFF_ADDR, 8'h7f);
        cpu.ioWrite(OFF_DATA, 8'ha5);
        cpu.ioWrite(OFF_CTRL, 8'h04);
        // strobe lands four edges after the arm edge, the last one allowed
        repeat (2) @(negedge clk);
        cpu.ioWrite(OFF_CTRL, 8'h02);
        t0 = cycleCount;
        expectReg("write busy", OFF_CTRL, 8'h02);
        cpu.waitIdle(ok);
        t0 = cycleCount - t0;
        check("write idle", 8'h01, {7'h00, ok});
        check("write time", 8'h01,
              8'(t0 >= WCYC - 3 && t0 <= WCYC + 8));
        check("write stall", 8'h02, 8'(stallCount));
        readBack(7'h7f, 8'ha5);
        cpu.writeByte(7'h00, 8'h3c, ok);
        check("idle 0", 8'h01, {7'h00, ok});
        cpu.writeByte(7'h01, 8'hc3, ok);
        check("idle 1", 8'h01, {7'h00, ok});
        readBack(7'h00, 8'h3c);
        readBack(7'h01, 8'hc3);
    endtask : t_write

    // a data write while programming must drop the write, old byte stays
    task automatic t_abort();
        logic ok;
        cpu.writeByte(7'h10, 8'h11, ok);
        check("abort idle 0", 8'h01, {7'h00, ok});
        readBack(7'h10, 8'h11);
        cpu.writeByte(7'h10, 8'h55, ok);
        check("abort idle 1", 8'h01, {7'h00, ok});
        cpu.ioWrite(OFF_DATA, 8'haa);
        expectReg("abort clear", OFF_CTRL, 8'h00);
        readBack(7'h10, 8'h11);
    endtask : t_abort

    task automatic stop_test();
        if (miscompares == 0 && totalChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : stop_test

////////////////////////////////////////
    initial
    begin
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        t_reset();
        t_bits();
        t_write();
        t_abort();
        stop_test();
    end

    // whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule : nac_ctrl_tb

`default_nettype wire
